// ---- core/level_sync.sv ----
// Two-flop synchroniser for a bundle of levels
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // level_sync

// ---- core/vector_select.sv ----
// Reset and interrupt vector address generator for the 26-entry two-word table
// How it works
// - With fuse unprogrammed, every system reset enters address 0x0000.
// - With fuse programmed, every reset enters the boot loader reset address.
// - Relocate bit set adds boot section start to each interrupt vector, not to the reset entry.
// - Table starts at 0x002, or boot address plus 0x0002, regardless of fuse.
// - Fuse value 1 means unprogrammed, 0 means programmed.
// - External request 0 at 0x0002, request 1 at 0x0004.
// - Pin change 0..2 at 0x0006, 0x0008, 0x000A; watchdog at 0x000C.
// - Timer 2 compare A 0x000E, compare B 0x0010, overflow 0x0012.
// - Timer 1 capture 0x0014, compare A 0x0016, B 0x0018, overflow 0x001A.
// - Timer 0 compare A 0x001C, compare B 0x001E, overflow 0x0020.
// - Serial transfer 0x0022; uart receive, empty, transmit 0x0024..0x0028.
// - ADC 0x002A, nvm 0x002C, comparator 0x002E, two-wire 0x0030, store 0x0032.
`include "vector_select_map.svh"
module vector_select
    import vector_select_pkg::*;
#(
    parameter pc_addr_t BOOT_RESET_ADDR = `VEC_BOOT_ADDR_DFLT
) (
    input  wire logic     core_clk,
    input  wire logic     rst_n,
    input  wire logic     boot_reset_fuse,
    input  wire logic     vector_table_relocate,
    input  wire irq_src_s irq_src,
    input  wire logic     irq_ack,
    output pc_addr_t      reset_addr_q,
    output vec_out_s      vec_q,
    output logic          reset_fetch_q
);
    irq_vec_t   irq_sync;
    vec_state_e state_q;
    logic       fuse_q;
    logic       fuse_sync;
    logic       irq_valid_d;
    logic [4:0] irq_index_d;
    logic [1:0] settle_q;

    // Fuses and requests arrive from outside this clock domain
    level_sync #(.WIDTH(`VEC_SRC_COUNT + 1)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({boot_reset_fuse, irq_src}),
        .sync_out ({fuse_sync, irq_sync})
    );

    // Nominal entry k sits at k times two words; entry 0 is reset
    function automatic pc_addr_t nominal_addr(input logic [4:0] entry);
        nominal_addr = pc_addr_t'({8'h00, entry} * `VEC_TABLE_STEP);
    endfunction

    function automatic pc_addr_t vector_addr(input logic [4:0] entry, input logic reloc);
        vector_addr = reloc ? pc_addr_t'(BOOT_RESET_ADDR + nominal_addr(entry))
                            : nominal_addr(entry);
    endfunction

    // Lowest table entry wins
    always_comb begin
        irq_valid_d = 1'b0;
        irq_index_d = 5'h00;
        for (int i = `VEC_SRC_COUNT - 1; i >= 0; i--) begin
            if (irq_sync[i]) begin
                irq_valid_d = 1'b1;
                irq_index_d = 5'(i + 1);
            end
        end
    end

    // Fuse caught after reset release, once synchronised; held until next reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q       <= ST_RESET;
            settle_q      <= 2'h0;
            fuse_q        <= `VEC_FUSE_UNPROG;
            reset_addr_q  <= `VEC_RESET_ADDR;
            reset_fetch_q <= 1'b0;
        end else begin
            reset_fetch_q <= 1'b0;
            unique case (state_q)
                // Synchroniser resets low, unlike an unprogrammed fuse; wait until it holds the pin
                ST_RESET: begin
                    settle_q <= settle_q + 2'h1;
                    if (settle_q == 2'(`VEC_SYNC_STAGES - 1)) begin
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    fuse_q        <= fuse_sync;
                    reset_addr_q  <= (fuse_sync == `VEC_FUSE_UNPROG) ? `VEC_RESET_ADDR
                                                                       : BOOT_RESET_ADDR;
                    reset_fetch_q <= 1'b1;
                    state_q       <= ST_RUN;
                end
                ST_RUN: state_q <= ST_RUN;
                default: state_q <= ST_RESET;
            endcase
        end
    end

    // Vector held until the core acknowledges; relocation bit sampled when each vector loads
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_q <= '0;
        end else if (state_q != ST_RUN) begin
            vec_q <= '0;
        end else if (!vec_q.valid || irq_ack) begin
            vec_q.valid <= irq_valid_d;
            vec_q.index <= irq_index_d;
            vec_q.addr  <= vector_addr(irq_index_d, vector_table_relocate);
        end
    end

    reset_unprog_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        reset_fetch_q && fuse_q |-> reset_addr_q == 13'h0000)
        else $error("reset entry not zero with fuse unprogrammed");

    reset_prog_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        reset_fetch_q && !fuse_q |-> reset_addr_q == BOOT_RESET_ADDR)
        else $error("reset entry not boot address with fuse programmed");

    fuse_sense_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(reset_fetch_q) |-> (reset_addr_q == 13'h0000) == fuse_q)
        else $error("fuse polarity wrong");

    reset_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        reset_fetch_q |=> !reset_fetch_q [*2])
        else $error("reset fetch repeated");

    reloc_offset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(vec_q.valid) && $past(vector_table_relocate)
            |-> vec_q.addr == pc_addr_t'(BOOT_RESET_ADDR + {7'h00, vec_q.index, 1'b0}))
        else $error("relocated vector not offset by boot start");

    table_base_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(vec_q.valid) && vec_q.index == 5'd1
            |-> vec_q.addr == ($past(vector_table_relocate) ? pc_addr_t'(BOOT_RESET_ADDR + 13'h0002) : 13'h0002))
        else $error("table start wrong");

    ext_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ST_RUN && !vec_q.valid && irq_src.ext_irq_one && !irq_src.ext_irq_zero
            ##2 (!vector_table_relocate && !vec_q.valid) [*1]
            |=> vec_q.addr == 13'h0004 || vec_q.index != 5'd2)
        else $error("external request one misplaced");

    watchdog_vec_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h06 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h000C)
        else $error("watchdog vector wrong");

    store_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h19 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h0032)
        else $error("program store vector wrong");

    ext_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h01 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h0002)
        else $error("external request zero vector wrong");

    pin_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h03 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h0006)
        else $error("pin change zero vector wrong");

    pin_two_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h05 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h000A)
        else $error("pin change two vector wrong");

    tmr2_cmpa_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h07 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h000E)
        else $error("timer two compare A vector wrong");

    tmr2_ovf_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h09 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h0012)
        else $error("timer two overflow vector wrong");

    tmr1_capt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h0A && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h0014)
        else $error("timer one capture vector wrong");

    tmr1_ovf_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h0D && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h001A)
        else $error("timer one overflow vector wrong");

    tmr0_cmpa_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h0E && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h001C)
        else $error("timer zero compare A vector wrong");

    tmr0_ovf_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h10 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h0020)
        else $error("timer zero overflow vector wrong");

    serial_done_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h11 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h0022)
        else $error("serial transfer vector wrong");

    uart_tx_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h14 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h0028)
        else $error("uart transmit vector wrong");

    adc_done_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h15 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h002A)
        else $error("converter vector wrong");

    nvm_ready_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h16 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h002C)
        else $error("nvm ready vector wrong");

    two_wire_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && vec_q.index == 5'h18 && !$past(vector_table_relocate) && $changed(vec_q.index)
            |-> vec_q.addr == 13'h0030)
        else $error("two-wire vector wrong");

    vec_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        vec_q.valid && !irq_ack && state_q == ST_RUN |=> $stable(vec_q))
        else $error("vector changed before acknowledge");
endmodule // vector_select

// ---- core/vector_select_map.svh ----
// Offsets, widths, reset values and timing counts of the vector select block
`ifndef VECTOR_SELECT_MAP_SVH
`define VECTOR_SELECT_MAP_SVH
`define VEC_RESET_ADDR       13'h0000
`define VEC_TABLE_STEP       13'h0002
`define VEC_FUSE_UNPROG      1'b1
`define VEC_BOOT_ADDR_DFLT   13'h1C00
`define VEC_SRC_COUNT        25
`define VEC_ENTRY_COUNT      26
`define VEC_SYNC_STAGES      2
`define VEC_PC_WIDTH         13
`endif

// ---- core/vector_select_pkg.sv ----
// Types shared by the vector select block
package vector_select_pkg;
    typedef logic [12:0] pc_addr_t;
    typedef logic [24:0] irq_vec_t;

    // Interrupt sources in table order, bit 0 is the highest-priority entry
    typedef struct packed {
        logic program_store_ready_irq;
        logic two_wire_irq;
        logic analog_comp_irq;
        logic nvm_data_ready_irq;
        logic adc_done_irq;
        logic uart_tx_done_irq;
        logic uart_tx_empty_irq;
        logic uart_rx_done_irq;
        logic serial_periph_done_irq;
        logic tmr0_ovf_irq;
        logic tmr0_cmp_b_irq;
        logic tmr0_cmp_a_irq;
        logic tmr1_ovf_irq;
        logic tmr1_cmp_b_irq;
        logic tmr1_cmp_a_irq;
        logic tmr1_capt_irq;
        logic tmr2_ovf_irq;
        logic tmr2_cmp_b_irq;
        logic tmr2_cmp_a_irq;
        logic watchdog_timeout_irq;
        logic pin_change_irq_two;
        logic pin_change_irq_one;
        logic pin_change_irq_zero;
        logic ext_irq_one;
        logic ext_irq_zero;
    } irq_src_s;

    typedef struct packed {
        logic     valid;
        logic [4:0] index;
        pc_addr_t addr;
    } vec_out_s;

    typedef enum logic [1:0] {
        ST_RESET  = 2'b00,
        ST_FETCH  = 2'b01,
        ST_RUN    = 2'b10
    } vec_state_e;
endpackage

// ---- verification/core_ack_model.sv ----
// Core-side model that acknowledges presented vectors after a chosen delay
module core_ack_model
    import vector_select_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire vec_out_s   vec_q,
    input  wire logic [3:0] ack_delay,
    output logic            irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    // One-cycle pulse, then idle so a reloaded vector restarts the count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q  <= 4'h0;
            irq_ack <= 1'b0;
        end else if (irq_ack || !vec_q.valid) begin
            wait_q  <= 4'h0;
            irq_ack <= 1'b0;
        end else begin
            wait_q  <= wait_q + 4'h1;
            irq_ack <= (wait_q + 4'h1 >= ack_delay);
        end
    end
endmodule // core_ack_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the vector select block
module tb_top;
    import vector_select_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Not the default, so the parameter path is really exercised
    localparam pc_addr_t BOOT = 13'h1E00;
    logic       core_clk, rst_n, boot_reset_fuse, vector_table_relocate, irq_ack, reset_fetch_q;
    logic [3:0] ack_delay;
    irq_src_s   irq_src;
    pc_addr_t   reset_addr_q;
    vec_out_s   vec_q;
    int         fails = 0;
    int         tests_run = 0;
    vector_select #(.BOOT_RESET_ADDR(BOOT)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .boot_reset_fuse(boot_reset_fuse), .vector_table_relocate(vector_table_relocate), .irq_src(irq_src),
        .irq_ack(irq_ack), .reset_addr_q(reset_addr_q), .vec_q(vec_q), .reset_fetch_q(reset_fetch_q));
    core_ack_model model (.core_clk(core_clk), .rst_n(rst_n), .vec_q(vec_q), .ack_delay(ack_delay),
        .irq_ack(irq_ack));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(string what, logic [12:0] exp, logic [12:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Waits for valid at lvl, and when high for the given index
    task automatic wait_vec(logic lvl, logic [4:0] idx);
        int n;
        n = 0;
        while (!(vec_q.valid === lvl && (!lvl || vec_q.index === idx)) && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 20) begin
            fails++;
            $display("[FAIL] vec_wait expected valid %b index %h seen valid %b index %h",
                     lvl, idx, vec_q.valid, vec_q.index);
            summarize();
        end
    endtask
    task automatic reset_with(logic fuse, pc_addr_t exp);
        int n;
        n = 0;
        @(posedge core_clk);
        rst_n <= 1'b0;
        boot_reset_fuse <= fuse;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        while (reset_fetch_q !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("reset_fetch", 13'h0001, {12'h000, reset_fetch_q});
        check("reset_addr", exp, reset_addr_q);
        if (n == 10) summarize();
        $display("reset test done, fuse %b", fuse);
    endtask
    task automatic table_walk(logic reloc);
        pc_addr_t base;
        base = reloc ? BOOT : 13'h0000;
        @(posedge core_clk);
        vector_table_relocate <= reloc;
        ack_delay <= 4'h4;
        for (int i = 0; i < 25; i++) begin
            @(posedge core_clk);
            irq_src <= irq_src_s'(25'h1 << i);
            wait_vec(1'b1, 5'(i + 1));
            check("vec_addr", base + 13'(2 * (i + 1)), vec_q.addr);
            check("vec_index", 13'(i + 1), {8'h00, vec_q.index});
            @(posedge core_clk);
            irq_src <= '0;
            wait_vec(1'b0, 5'h00);
        end
        $display("table test done, relocate %b", reloc);
    endtask
    // Two pending lines: lower entry first, next loaded on the ack edge
    task automatic prio_pair();
        @(posedge core_clk);
        vector_table_relocate <= 1'b0;
        ack_delay <= 4'h6;
        irq_src <= irq_src_s'(25'h000000A);
        wait_vec(1'b1, 5'h02);
        check("first_addr", 13'h0004, vec_q.addr);
        @(posedge core_clk);
        irq_src.ext_irq_one <= 1'b0;
        wait_vec(1'b1, 5'h04);
        check("second_addr", 13'h0008, vec_q.addr);
        @(posedge core_clk);
        irq_src <= '0;
        wait_vec(1'b0, 5'h00);
        $display("priority test done");
    endtask
    initial begin
        rst_n = 1'b0;
        boot_reset_fuse = 1'b1;
        vector_table_relocate = 1'b0;
        irq_src = '0;
        ack_delay = 4'h4;
        reset_with(1'b1, 13'h0000);
        table_walk(1'b0);
        table_walk(1'b1);
        reset_with(1'b0, BOOT);
        table_walk(1'b1);
        table_walk(1'b0);
        prio_pair();
        summarize();
    end
endmodule // tb_top
